// ==== rtl/tcm_pkg.sv ====
// package of constants for the dual channel torque cutoff monitor
package tcm_pkg;
   // ==========================================
   // clock and timing
   localparam int CLK_HZ = 100_000_000;
   localparam int FAST_WIN_MS = 100;
   localparam int DISC_WIN_MS = 1000;
   localparam int RESP_MAX_MS = 12;
   localparam int FAST_WIN_CYC = FAST_WIN_MS * (CLK_HZ / 1000);
   localparam int DISC_WIN_CYC = DISC_WIN_MS * (CLK_HZ / 1000);
   localparam int TMR_W = 28;
   // ==========================================
   // register map (byte addresses)
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h4;
   localparam logic [3:0] ADDR_INHIBIT = 4'h8;
   // status field positions
   localparam int ST_HALT = 0;
   localparam int ST_FAULT = 1;
   localparam int ST_CH0 = 2;
   localparam int ST_CH1 = 3;
   localparam int ST_GATE_OFF = 4;
   localparam int ST_RESET_OK = 5;
   // control field positions
   localparam int CT_FAULT_RESET = 0;
   // start inhibit codes
   localparam logic [3:0] INHIBIT_NONE = 4'h0;
   localparam logic [3:0] INHIBIT_CUTOFF = 4'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================
   // monitor states, gray along the usual path except the TCM_SETTLE to TCM_RUN step
   typedef enum logic [2:0] {
      TCM_RUN = 3'b000,
      TCM_ONE_OFF = 3'b001,
      TCM_BOTH_OFF = 3'b011,
      TCM_ONE_ON = 3'b010,
      TCM_SETTLE = 3'b110,
      TCM_FAULT = 3'b100
   } tcm_state_t;
endpackage

// ==== rtl/tcm_monitor.sv ====
// dual channel torque cutoff monitor with axi4-lite status access
`timescale 1ns/1ps
// Notes on behaviour
// R1 - either enable input off forces every power transistor gate signal off.
// R2 - gates turn off well inside 12 ms of an input dropping.
// R3 - input drop sets cutoff inhibit code and halt request flag.
// R4 - partner drops second input within 1 s, before first returns.
// R5 - partner re-energizes second input within 1 s of the first.
// R6 - second input back within 100 ms clears halt flag at once.
// R7 - second input back after 100 ms clears halt flag at 1 s.
// R8 - first returning while second never dropped still raises mismatch fault.
// R9 - mismatch is only evaluated after an input drops, never while both on.
// R10 - fault reset accepted only after both inputs off over 1 s.
// R11 - fault clears only by explicit axis fault reset command.
// R12 - inputs are synchronised; windows are counted in clock cycles.
// R13 - while faulted, gates stay off and halt flag stays set.
module tcm_monitor #(
   parameter int FAST_CYC = tcm_pkg::FAST_WIN_CYC,
   parameter int DISC_CYC = tcm_pkg::DISC_WIN_CYC,
   parameter int GATES = 6
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // safety enable pins, high when energized
   input wire logic safety_enable_ch0,
   input wire logic safety_enable_ch1,
   // power transistor gate enables and status
   output logic [GATES-1:0] gate_enable,
   output logic halt_request_flag,
   output logic input_mismatch_fault,
   output logic [3:0] start_inhibit,
   // axi4-lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ==========================================
   // input synchronisers
   logic [2:0] sync0_reg, sync0_next, sync1_reg, sync1_next;
   logic ch0_reg, ch0_next, ch1_reg, ch1_next;
   always_comb begin
      sync0_next = {sync0_reg[1:0], safety_enable_ch0};
      sync1_next = {sync1_reg[1:0], safety_enable_ch1};
      ch0_next = ch0_reg;
      ch1_next = ch1_reg;
      if (sync0_reg[2] == sync0_reg[1]) begin
         ch0_next = sync0_reg[2]; // R12
      end
      if (sync1_reg[2] == sync1_reg[1]) begin
         ch1_next = sync1_reg[2]; // R12
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync0_reg <= 3'h0;
         sync1_reg <= 3'h0;
         ch0_reg <= 1'b0;
         ch1_reg <= 1'b0;
      end else begin
         sync0_reg <= sync0_next;
         sync1_reg <= sync1_next;
         ch0_reg <= ch0_next;
         ch1_reg <= ch1_next;
      end
   end
   // ==========================================
   // monitor state machine
   tcm_pkg::tcm_state_t state_reg, state_next;
   logic [tcm_pkg::TMR_W-1:0] tmr_reg, tmr_next;
   logic halt_reg, halt_next;
   logic first_ch_reg, first_ch_next;
   logic reset_ok_reg, reset_ok_next;
   logic fault_reset_cmd;
   logic both_on, both_off, first_on, other_on, tmr_disc;
   assign both_on = ch0_reg && ch1_reg;
   assign both_off = !ch0_reg && !ch1_reg;
   assign first_on = first_ch_reg ? ch1_reg : ch0_reg;
   assign other_on = first_ch_reg ? ch0_reg : ch1_reg;
   assign tmr_disc = tmr_reg >= tcm_pkg::TMR_W'(DISC_CYC);
   always_comb begin
      state_next = state_reg;
      halt_next = halt_reg;
      first_ch_next = first_ch_reg;
      reset_ok_next = reset_ok_reg;
      tmr_next = tmr_disc ? tmr_reg : tmr_reg + 1'b1;
      unique case (state_reg)
         tcm_pkg::TCM_RUN: begin
            tmr_next = '0;
            if (!both_on) begin // R9
               halt_next = 1'b1; // R3
               first_ch_next = !ch0_reg;
               state_next = both_off ? tcm_pkg::TCM_BOTH_OFF : tcm_pkg::TCM_ONE_OFF;
            end
         end
         tcm_pkg::TCM_ONE_OFF: begin
            if (both_off) begin
               state_next = tcm_pkg::TCM_BOTH_OFF;
               tmr_next = '0;
            end else if (tmr_disc || both_on) begin
               state_next = tcm_pkg::TCM_FAULT; // R4 R8
            end
         end
         tcm_pkg::TCM_BOTH_OFF: begin
            if (!both_off) begin
               first_ch_next = ch1_reg;
               state_next = both_on ? tcm_pkg::TCM_SETTLE : tcm_pkg::TCM_ONE_ON;
               tmr_next = '0;
               if (both_on) begin
                  halt_next = 1'b0; // R6
               end
            end
         end
         tcm_pkg::TCM_ONE_ON: begin
            if (!first_on) begin
               state_next = tcm_pkg::TCM_FAULT;
               tmr_next = '0;
            end else if (tmr_disc) begin
               state_next = tcm_pkg::TCM_FAULT; // R5
            end else if (other_on) begin
               state_next = tcm_pkg::TCM_SETTLE;
               if (tmr_reg < tcm_pkg::TMR_W'(FAST_CYC)) begin
                  halt_next = 1'b0; // R6
               end
            end
         end
         tcm_pkg::TCM_SETTLE: begin
            if (!both_on) begin
               halt_next = 1'b1; // R3
               first_ch_next = !ch0_reg;
               tmr_next = '0;
               state_next = both_off ? tcm_pkg::TCM_BOTH_OFF : tcm_pkg::TCM_ONE_OFF;
            end else if (tmr_disc) begin
               halt_next = 1'b0; // R7
               state_next = tcm_pkg::TCM_RUN;
            end
         end
         tcm_pkg::TCM_FAULT: begin
            halt_next = 1'b1; // R13
            if (!both_off) begin
               tmr_next = '0;
               reset_ok_next = 1'b0;
            end else if (tmr_disc) begin
               reset_ok_next = 1'b1; // R10
            end
            if (fault_reset_cmd && reset_ok_reg) begin
               reset_ok_next = 1'b0;
               tmr_next = '0;
               state_next = tcm_pkg::TCM_BOTH_OFF; // R11
            end
         end
         default: begin
            state_next = tcm_pkg::TCM_FAULT;
         end
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= tcm_pkg::TCM_BOTH_OFF;
         tmr_reg <= '0;
         halt_reg <= 1'b1;
         first_ch_reg <= 1'b0;
         reset_ok_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tmr_reg <= tmr_next;
         halt_reg <= halt_next;
         first_ch_reg <= first_ch_next;
         reset_ok_reg <= reset_ok_next;
      end
   end
   // ==========================================
   // gate drive, registered from the next filtered inputs, on the same edge as ch0_reg and ch1_reg
   logic gate_on_reg, gate_on_next;
   // gates conduct only on the legal return path, so a mismatch cannot pulse them on
   assign gate_on_next = ch0_next && ch1_next
                         && (state_next == tcm_pkg::TCM_SETTLE || state_next == tcm_pkg::TCM_RUN); // R1 R2 R13
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gate_on_reg <= 1'b0;
      end else begin
         gate_on_reg <= gate_on_next;
      end
   end
   assign gate_enable = {GATES{gate_on_reg}}; // R1
   assign halt_request_flag = halt_reg;
   assign input_mismatch_fault = state_reg == tcm_pkg::TCM_FAULT;
   assign start_inhibit = halt_reg ? tcm_pkg::INHIBIT_CUTOFF : tcm_pkg::INHIBIT_NONE; // R3
   // ==========================================
   // axi4-lite slave
   logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
   logic [3:0] awa_reg, awa_next;
   logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
   logic [1:0] br_reg, br_next, rr_reg, rr_next;
   logic [31:0] status_word;
   always_comb begin
      status_word = '0;
      status_word[tcm_pkg::ST_HALT] = halt_reg;
      status_word[tcm_pkg::ST_FAULT] = input_mismatch_fault;
      status_word[tcm_pkg::ST_CH0] = ch0_reg;
      status_word[tcm_pkg::ST_CH1] = ch1_reg;
      status_word[tcm_pkg::ST_GATE_OFF] = !gate_on_reg;
      status_word[tcm_pkg::ST_RESET_OK] = reset_ok_reg;
   end
   assign s_axi_awready = !aw_reg && !bv_reg;
   assign s_axi_wready = !w_reg && !bv_reg;
   assign s_axi_arready = !rv_reg;
   assign s_axi_bvalid = bv_reg;
   assign s_axi_bresp = br_reg;
   assign s_axi_rvalid = rv_reg;
   assign s_axi_rdata = rd_reg;
   assign s_axi_rresp = rr_reg;
   assign fault_reset_cmd = aw_reg && w_reg && (awa_reg == tcm_pkg::ADDR_CTRL) && wd_reg[tcm_pkg::CT_FAULT_RESET];
   always_comb begin
      aw_next = aw_reg;
      w_next = w_reg;
      awa_next = awa_reg;
      wd_next = wd_reg;
      bv_next = bv_reg;
      br_next = br_reg;
      rv_next = rv_reg;
      rd_next = rd_reg;
      rr_next = rr_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_next = 1'b1;
         awa_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_next = 1'b1;
         wd_next = s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
      end
      if (aw_reg && w_reg) begin
         aw_next = 1'b0;
         w_next = 1'b0;
         bv_next = 1'b1;
         br_next = (awa_reg == tcm_pkg::ADDR_CTRL) ? tcm_pkg::RESP_OKAY : tcm_pkg::RESP_SLVERR;
      end
      if (bv_reg && s_axi_bready) begin
         bv_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_next = 1'b1;
         rr_next = tcm_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            tcm_pkg::ADDR_STATUS: rd_next = status_word;
            tcm_pkg::ADDR_CTRL: rd_next = 32'h0000_0000;
            tcm_pkg::ADDR_INHIBIT: rd_next = {28'h000_0000, start_inhibit};
            default: begin
               rd_next = 32'h0000_0000;
               rr_next = tcm_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rv_reg && s_axi_rready) begin
         rv_next = 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         awa_reg <= 4'h0;
         wd_reg <= 32'h0000_0000;
         bv_reg <= 1'b0;
         br_reg <= 2'h0;
         rv_reg <= 1'b0;
         rd_reg <= 32'h0000_0000;
         rr_reg <= 2'h0;
      end else begin
         aw_reg <= aw_next;
         w_reg <= w_next;
         awa_reg <= awa_next;
         wd_reg <= wd_next;
         bv_reg <= bv_next;
         br_reg <= br_next;
         rv_reg <= rv_next;
         rd_reg <= rd_next;
         rr_reg <= rr_next;
      end
   end
endmodule

// ==== tb/tcm_monitor_assertions.sv ====
// assertions on the torque cutoff monitor ports
`timescale 1ns/1ps
module tcm_monitor_assertions #(
   parameter int GATES = 6
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // pins and status
   input wire logic safety_enable_ch0,
   input wire logic safety_enable_ch1,
   input wire logic [GATES-1:0] gate_enable,
   input wire logic halt_request_flag,
   input wire logic input_mismatch_fault,
   input wire logic [3:0] start_inhibit,
   // bus handshakes
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // cycles since either pin was last low
   logic [7:0] since_low;
   always_ff @(posedge aclk) begin
      since_low <= (!safety_enable_ch0 || !safety_enable_ch1) ? 8'h00 : since_low + {7'h00, since_low != 8'hFF};
   end
   // ==========
   // properties
   sequence s_drop;
      $fell(safety_enable_ch0) || $fell(safety_enable_ch1);
   endsequence
   property p_drop_gate;
      s_drop |-> ##[1:8] gate_enable == '0;
   endproperty
   a_drop_gate: assert property (p_drop_gate) else $error("gates on after drop");
   property p_drop_halt;
      s_drop |-> ##[1:8] halt_request_flag;
   endproperty
   a_drop_halt: assert property (p_drop_halt) else $error("no halt after drop");
   property p_inhibit;
      start_inhibit == (halt_request_flag ? tcm_pkg::INHIBIT_CUTOFF : tcm_pkg::INHIBIT_NONE);
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("bad inhibit code");
   property p_fault_hold;
      input_mismatch_fault |-> gate_enable == '0 && halt_request_flag;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault not safe");
   property p_fault_cause;
      $rose(input_mismatch_fault) |-> since_low <= 8'h08;
   endproperty
   a_fault_cause: assert property (p_fault_cause) else $error("fault while both on");
   property p_fault_clear;
      $fell(input_mismatch_fault) |-> (!safety_enable_ch0 && !safety_enable_ch1) ##[0:1] s_axi_bvalid;
   endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("fault cleared alone");
   property p_halt_clear;
      $fell(halt_request_flag) |-> safety_enable_ch0 && safety_enable_ch1;
   endproperty
   a_halt_clear: assert property (p_halt_clear) else $error("halt cleared early");
   property p_read_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_read_resp: assert property (p_read_resp) else $error("no read answer");
endmodule
bind tcm_monitor tcm_monitor_assertions #(.GATES(GATES)) u_chk (.*);

// ==== tb/tcm_safety_partner.sv ====
// external safety device driving both enable pins
`timescale 1ns/1ps
module tcm_safety_partner (
   // clock and controls
   input wire logic aclk,
   input wire logic demand_on,
   input wire logic first_ch1,
   input wire logic [7:0] lag,
   input wire logic stuck,
   // enable pins
   output logic safety_enable_ch0,
   output logic safety_enable_ch1
);
   logic lead = 1'b0;
   logic follow = 1'b0;
   logic [7:0] cnt = 8'h00;
   // second channel trails the first by lag plus one cycles
   always @(posedge aclk) begin
      lead <= demand_on;
      cnt <= (demand_on != lead) ? 8'h00 : cnt + {7'h00, cnt != 8'hFF};
      if (!stuck && demand_on == lead && cnt >= lag) begin
         follow <= lead;
      end
   end
   assign safety_enable_ch0 = first_ch1 ? follow : lead;
   assign safety_enable_ch1 = first_ch1 ? lead : follow;
endmodule

// ==== tb/testbench.sv ====
// self-checking testbench for the torque cutoff monitor
`timescale 1ns/1ps
module testbench;
   logic aclk = 1'b0;
   logic aresetn, demand_on, first_ch1, stuck, safety_enable_ch0, safety_enable_ch1;
   logic halt_request_flag, input_mismatch_fault, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] lag;
   logic [5:0] gate_enable;
   logic [3:0] start_inhibit, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [65:0] rq[$];
   logic [1:0] bq[$];
   logic [65:0] e;
   int n_errors = 0;
   int check_count = 0;
   int seed = 70098;
   always #5 aclk = ~aclk;
   tcm_monitor #(.FAST_CYC(20), .DISC_CYC(100)) DUT (.*);
   tcm_safety_partner PM (.*);
   task automatic complete_run;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic chk(input logic [65:0] got, input logic [65:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic f, input logic h, input logic g);
      chk({input_mismatch_fault, halt_request_flag, start_inhibit, gate_enable},
          {f, h, h ? tcm_pkg::INHIBIT_CUTOFF : tcm_pkg::INHIBIT_NONE, {6{g}}});
   endtask
   // one bus transfer; expected answer goes to the queue
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [1:0] r);
      int n;
      @(posedge aclk);
      if (wr) bq.push_back(r);
      else rq.push_back({r, m, d});
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_arvalid <= !wr;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_bvalid || s_axi_rvalid) break;
      end
      if (n == 20) begin
         n_errors++;
         complete_run();
      end
   endtask
   // an answer with no note, or an unknown valid, counts as a mismatch
   always @(posedge aclk) begin
      if (aresetn && s_axi_rvalid !== 1'b0 && s_axi_rready) begin
         e = (rq.size() > 0) ? rq.pop_front() : 'x;
         chk({s_axi_rresp, s_axi_rdata & e[63:32]}, {e[65:64], e[31:0]});
      end
      if (aresetn && s_axi_bvalid !== 1'b0 && s_axi_bready) begin
         chk(s_axi_bresp, (bq.size() > 0) ? bq.pop_front() : 2'hX);
      end
   end
   task automatic recover;
      stuck <= 1'b0;
      lag <= 8'h00;
      demand_on <= 1'b0;
      cyc(120);
      bus(1'b0, tcm_pkg::ADDR_STATUS, 32'h33, 32'h3F, tcm_pkg::RESP_OKAY);
      bus(1'b1, tcm_pkg::ADDR_CTRL, 32'h1, 32'h0, tcm_pkg::RESP_OKAY);
      cyc(3);
      chk_pin(1'b0, 1'b1, 1'b0);
      demand_on <= 1'b1;
      cyc(10);
      chk_pin(1'b0, 1'b0, 1'b1);
   endtask
   initial begin
      {aresetn, demand_on, first_ch1, stuck, lag, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
      cyc(2);
      aresetn <= 1'b1;
      cyc(1);
      chk_pin(1'b0, 1'b1, 1'b0);
      demand_on <= 1'b1;
      cyc(10);
      chk_pin(1'b0, 1'b0, 1'b1);
      bus(1'b0, tcm_pkg::ADDR_STATUS, 32'hC, 32'h1F, tcm_pkg::RESP_OKAY);
      bus(1'b1, tcm_pkg::ADDR_STATUS, $random(seed), 32'h0, tcm_pkg::RESP_SLVERR);
      bus(1'b0, 4'hC, 32'h0, 32'hFFFFFFFF, tcm_pkg::RESP_SLVERR);
      cyc(300);
      chk_pin(1'b0, 1'b0, 1'b1);
      lag <= 8'($random(seed) & 15);
      demand_on <= 1'b0;
      cyc(8);
      chk_pin(1'b0, 1'b1, 1'b0);
      bus(1'b0, tcm_pkg::ADDR_INHIBIT, {28'h0, tcm_pkg::INHIBIT_CUTOFF}, 32'hF, tcm_pkg::RESP_OKAY);
      cyc(20);
      demand_on <= 1'b1;
      cyc(lag + 9);
      chk_pin(1'b0, 1'b0, 1'b1);
      demand_on <= 1'b0;
      cyc(20);
      first_ch1 <= 1'b1;
      lag <= 8'h32;
      demand_on <= 1'b1;
      cyc(70);
      bus(1'b0, tcm_pkg::ADDR_STATUS, 32'h1, 32'h3, tcm_pkg::RESP_OKAY);
      cyc(40);
      chk_pin(1'b0, 1'b0, 1'b1);
      first_ch1 <= 1'b0;
      stuck <= 1'b1;
      demand_on <= 1'b0;
      cyc(10);
      demand_on <= 1'b1;
      cyc(10);
      chk_pin(1'b1, 1'b1, 1'b0);
      bus(1'b1, tcm_pkg::ADDR_CTRL, 32'h1, 32'h0, tcm_pkg::RESP_OKAY);
      cyc(2);
      chk_pin(1'b1, 1'b1, 1'b0);
      recover();
      stuck <= 1'b1;
      demand_on <= 1'b0;
      cyc(110);
      chk_pin(1'b1, 1'b1, 1'b0);
      recover();
      demand_on <= 1'b0;
      cyc(20);
      lag <= 8'h96;
      demand_on <= 1'b1;
      cyc(120);
      chk_pin(1'b1, 1'b1, 1'b0);
      recover();
      complete_run();
   end
endmodule
